// >>> src/hbpm_top.sv
// host bus pin mapper: data lane mapping, strobe roles, select gating, bus clock tick
`timescale 1ns/10ps

// Operation
// (R1) The 16-bit two-way data bus is shared by every bus mode and host lanes map onto it per mode.
// (R2) In the companion-chip modes the host wires its bits 23..16 to the upper byte and 31..24 to the lower byte.
// (R3) In the single-strobe mode a 32-bit host wires its upper half-word and a 16-bit host its lower one.
// (R4) In the big-endian-numbered mode host bit 0 lands on the most significant device data bit.
// (R5) In per-byte-write and generic modes the upper-byte strobe is the active-low upper write enable.
// (R6) In the strobe-pair mode the upper-byte strobe is the active-low upper data strobe for lane 15..8.
// (R7) In the single-strobe mode the upper-byte strobe is the one active-low data strobe, size given apart.
// (R8) In the isa-style mode the upper-byte strobe is the active-low byte-high enable.
// (R9) In the companion-chip modes the upper-byte strobe is the active-low odd-byte enable.
// (R10) In the big-endian-numbered mode the upper-byte strobe pin is driven as an active-low burst inhibit.
// (R11) In the pc card mode the upper-byte strobe is the active-low card enable two for the high byte.
// (R12) Space select high picks the display buffer and low the registers, tied high in companion modes.
// (R13) Cycles are accepted only under active-low chip select, except in companion modes where it is tied.
// (R14) Interface timing follows the bus clock, optionally a doubled clock halved inside.
// (R15) In pc card mode the bus clock is fed from the device's own input clock source.
// (R16) Data bus and burst inhibit float during reset and data is driven only on reads that select the device.
module hbpm_top #(
  parameter int unsigned DATA_W = hbpm_pkg::DATA_W  // data bus width
) (
  input  wire logic              clk_i,                  // 40 MHz core clock
  input  wire logic              srst_i,                 // synchronous reset, active high
  input  wire logic [3:0]        bus_mode_i,             // selected host bus type
  input  wire logic              clock_halving_strap_i,  // bus clock is doubled, halve it
  input  wire logic              host_bus_clock_i,       // host bus clock pin, sampled
  input  wire logic [DATA_W-1:0] host_data_lines_i,      // data pins, input side
  output logic      [DATA_W-1:0] host_data_lines_o,      // data pins, output side
  output logic                   host_data_lines_oe_o,   // data pins driven
  input  wire logic              upper_byte_strobe_n_i,  // strobe pin, input side
  output logic                   upper_byte_strobe_n_o,  // strobe pin, burst inhibit out
  output logic                   upper_byte_strobe_oe_o, // strobe pin driven
  input  wire logic              space_select_i,         // high buffer, low registers
  input  wire logic              chip_select_n_i,        // chip select, active low
  input  wire logic              host_read_i,            // current cycle is a read
  input  wire logic              burst_inhibit_i,        // core asks to inhibit bursts
  input  wire logic [DATA_W-1:0] core_rdata_i,           // read data from core
  output logic                   bus_tick_o,             // one pulse per bus clock period
  output logic                   cycle_sel_o,            // device selected this cycle
  output logic                   space_buffer_o,         // access targets display buffer
  output logic                   upper_lane_o,           // upper byte takes part
  output logic                   upper_we_o,             // upper byte write enable
  output logic                   data_strobe_o,          // single data strobe active
  output logic      [DATA_W-1:0] core_wdata_o            // write data in device lane order
);

  generate
    if (DATA_W != hbpm_pkg::DATA_W) begin : g_bad_width
      $error("hbpm_top: data bus must be 16 bits");
    end
  endgenerate

  localparam int unsigned LW = hbpm_pkg::LANE_W;

  // companion busses wire the host's high bytes crossed over
  function automatic logic [DATA_W-1:0] lane_map(input logic [3:0] mode, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = d;
    if (mode == hbpm_pkg::MODE_COMP_A || mode == hbpm_pkg::MODE_COMP_B) begin
      r = {d[LW-1:0], d[DATA_W-1:LW]};
    end
    return r;
  endfunction : lane_map

  function automatic logic is_companion(input logic [3:0] mode);
    return (mode == hbpm_pkg::MODE_COMP_A) || (mode == hbpm_pkg::MODE_COMP_B);
  endfunction : is_companion

  ////////////////////////////////////////////////////////////////////////////
  // bus clock sampling and halving

  logic strap_r;
  logic strap_nxt;
  logic strap_seen_r;
  logic strap_seen_nxt;
  logic bclk_q_r;
  logic bclk_q_nxt;
  logic half_r;
  logic half_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    strap_nxt      = strap_r;
    strap_seen_nxt = 1'b1;
    bclk_q_nxt     = host_bus_clock_i;
    half_nxt       = half_r;
    tick_nxt       = 1'b0;
    // strap is caught once, on the first cycle after reset release
    if (!strap_seen_r) begin
      strap_nxt = clock_halving_strap_i;                  // R14
    end
    // the pin is synchronous to clk_i, so a rising edge is seen by plain compare
    if (host_bus_clock_i && !bclk_q_r) begin
      if (strap_r) begin
        half_nxt = ~half_r;                               // R14
        tick_nxt = half_r;                                // R14
      end else begin
        tick_nxt = 1'b1;                                  // R14
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_r      <= 1'b0;
      strap_seen_r <= 1'b0;
      bclk_q_r     <= 1'b0;
      half_r       <= 1'b0;
      tick_r       <= 1'b0;
    end else begin
      strap_r      <= strap_nxt;
      strap_seen_r <= strap_seen_nxt;
      bclk_q_r     <= bclk_q_nxt;
      half_r       <= half_nxt;
      tick_r       <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe pin roles

  logic dec_upper_lane;
  logic dec_upper_we;
  logic dec_data_strobe;
  logic dec_pin_out;

  hbpm_strobe_decode u_strobe (
    .mode_i          (bus_mode_i),
    .strobe_n_i      (upper_byte_strobe_n_i),
    .rd_cycle_i      (host_read_i),
    .upper_lane_o    (dec_upper_lane),
    .upper_we_o      (dec_upper_we),
    .data_strobe_o   (dec_data_strobe),
    .pin_is_output_o (dec_pin_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // cycle qualification and data path

  logic              sel_r;
  logic              sel_nxt;
  logic              space_r;
  logic              space_nxt;
  logic              lane_r;
  logic              lane_nxt;
  logic              we_r;
  logic              we_nxt;
  logic              ds_r;
  logic              ds_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic              doe_r;
  logic              doe_nxt;
  logic              bi_n_r;
  logic              bi_n_nxt;
  logic              bi_oe_r;
  logic              bi_oe_nxt;

  always_comb begin
    // companion busses have chip select and space select strapped high
    sel_nxt   = is_companion(bus_mode_i) ? 1'b1 : ~chip_select_n_i;          // R13
    space_nxt = is_companion(bus_mode_i) ? 1'b1 : space_select_i;            // R12
    lane_nxt  = sel_nxt & dec_upper_lane;
    we_nxt    = sel_nxt & dec_upper_we;                                      // R5
    ds_nxt    = sel_nxt & dec_data_strobe;                                   // R7
    // big-endian numbering only renames bits: host D0 already sits on bit 15
    wdata_nxt = lane_map(bus_mode_i, host_data_lines_i);                     // R1 R2 R3 R4
    dout_nxt  = lane_map(bus_mode_i, core_rdata_i);                          // R1 R2
    doe_nxt   = sel_nxt & host_read_i;                                       // R16
    bi_oe_nxt = dec_pin_out;                                                 // R10
    bi_n_nxt  = ~burst_inhibit_i;                                            // R10
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_r   <= 1'b0;
      space_r <= 1'b0;
      lane_r  <= 1'b0;
      we_r    <= 1'b0;
      ds_r    <= 1'b0;
      wdata_r <= hbpm_pkg::DATA_RST;
      dout_r  <= hbpm_pkg::DATA_RST;
      doe_r   <= 1'b0;                                                       // R16
      bi_n_r  <= hbpm_pkg::BI_N_RST;
      bi_oe_r <= 1'b0;                                                       // R16
    end else begin
      sel_r   <= sel_nxt;
      space_r <= space_nxt;
      lane_r  <= lane_nxt;
      we_r    <= we_nxt;
      ds_r    <= ds_nxt;
      wdata_r <= wdata_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      bi_n_r  <= bi_n_nxt;
      bi_oe_r <= bi_oe_nxt;
    end
  end

  assign host_data_lines_o      = dout_r;
  assign host_data_lines_oe_o   = doe_r;
  assign upper_byte_strobe_n_o  = bi_n_r;
  assign upper_byte_strobe_oe_o = bi_oe_r;
  assign bus_tick_o             = tick_r;
  assign cycle_sel_o            = sel_r;
  assign space_buffer_o         = space_r;
  assign upper_lane_o           = lane_r;
  assign upper_we_o             = we_r;
  assign data_strobe_o          = ds_r;
  assign core_wdata_o           = wdata_r;

endmodule : hbpm_top

// >>> src/hbpm_pkg.sv
// constants and types shared by the host bus pin mapper
package hbpm_pkg;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned MODE_W     = 4;

  // clock figures
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned CLK_PER_NS = 25;
  localparam int unsigned HALVE_DIV  = 2;

  // selectable host bus types
  typedef enum logic [3:0] {
    MODE_BYTE_WE     = 4'h0,  // per-byte write strobes
    MODE_STROBE_PAIR = 4'h1,  // upper/lower data strobes
    MODE_SINGLE_DS   = 4'h2,  // single data strobe, size separate
    MODE_GENERIC     = 4'h3,  // generic bus
    MODE_BYTE_HIGH   = 4'h4,  // isa style byte-high enable
    MODE_COMP_A      = 4'h5,  // companion-chip bus, first variant
    MODE_COMP_B      = 4'h6,  // companion-chip bus, second variant
    MODE_BE_NUM      = 4'h7,  // big-endian-numbered bus
    MODE_CARD        = 4'h8   // pc card bus
  } hbpm_mode_t;

  // reset values of the pins this block can drive
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic        BI_N_RST    = 1'h1;

endpackage : hbpm_pkg

// >>> src/hbpm_strobe_decode.sv
// decodes the multi-purpose upper-byte strobe pin per bus mode
`timescale 1ns/10ps
module hbpm_strobe_decode (
  input  wire logic [3:0] mode_i,           // selected bus mode
  input  wire logic       strobe_n_i,       // sampled upper-byte strobe pin
  input  wire logic       rd_cycle_i,       // cycle is a host read
  output logic            upper_lane_o,     // upper byte takes part
  output logic            upper_we_o,       // upper byte write enable
  output logic            data_strobe_o,    // whole-transfer strobe
  output logic            pin_is_output_o   // pin turns around to output
);

  always_comb begin
    upper_lane_o    = 1'b0;
    upper_we_o      = 1'b0;
    data_strobe_o   = 1'b0;
    pin_is_output_o = 1'b0;
    case (mode_i)
      hbpm_pkg::MODE_BYTE_WE,
      hbpm_pkg::MODE_GENERIC: begin
        upper_we_o   = ~strobe_n_i;                       // R5
        upper_lane_o = ~strobe_n_i;                       // R5
      end
      hbpm_pkg::MODE_STROBE_PAIR: begin
        upper_lane_o = ~strobe_n_i;                       // R6
        upper_we_o   = ~strobe_n_i & ~rd_cycle_i;         // R6
      end
      hbpm_pkg::MODE_SINGLE_DS: begin
        // lane choice comes from this pin, the size inputs are not decoded here
        data_strobe_o = ~strobe_n_i;                      // R7
        upper_lane_o  = ~strobe_n_i;                      // R7
        upper_we_o    = ~strobe_n_i & ~rd_cycle_i;        // R7
      end
      hbpm_pkg::MODE_BYTE_HIGH: begin
        upper_lane_o = ~strobe_n_i;                       // R8
        upper_we_o   = ~strobe_n_i & ~rd_cycle_i;         // R8
      end
      hbpm_pkg::MODE_COMP_A,
      hbpm_pkg::MODE_COMP_B: begin
        upper_lane_o = ~strobe_n_i;                       // R9
        upper_we_o   = ~strobe_n_i & ~rd_cycle_i;         // R9
      end
      hbpm_pkg::MODE_BE_NUM: begin
        pin_is_output_o = 1'b1;                           // R10
      end
      hbpm_pkg::MODE_CARD: begin
        upper_lane_o = ~strobe_n_i;                       // R11
        upper_we_o   = ~strobe_n_i & ~rd_cycle_i;         // R11
      end
      default: begin
        upper_lane_o = 1'b0;
      end
    endcase
  end

endmodule : hbpm_strobe_decode

// >>> verification/hbpm_host_model.sv
// host bus master model: bus clock source and data pin resolution
`timescale 1ns/10ps
module hbpm_host_model (
  input  wire logic        clk_i,       // core clock, also the card-mode clock source
  input  wire logic        run_i,       // bus clock runs only while high
  input  wire logic        drive_i,     // host drives the data pins
  input  wire logic [15:0] wdata_i,     // host write data
  input  wire logic [15:0] dev_data_i,  // device data pins, output side
  input  wire logic        dev_oe_i,    // device drives the data pins
  output logic             bus_clk_o,   // bus clock to the device
  output logic      [15:0] data_o       // resolved data pin level
);
  logic [1:0]  div_r  = 2'h0;
  logic [15:0] last_r = 16'h0000;
  initial bus_clk_o = 1'b0;
  // bus clock derived from the device clock, held low between frames
  always @(negedge clk_i) begin
    div_r  <= run_i ? div_r + 2'h1 : 2'h0;
    bus_clk_o <= run_i ? (div_r[0] ? ~bus_clk_o : bus_clk_o) : 1'b0;
    last_r <= data_o;
  end
  // released pins show a changing pattern so a stale value never matches
  assign data_o = dev_oe_i ? dev_data_i : (drive_i ? wdata_i : ~last_r);
endmodule : hbpm_host_model

// >>> verification/hbpm_top_chk.sv
// concurrent checks on the ports of the host bus pin mapper
`timescale 1ns/10ps
module hbpm_top_chk #(
  parameter int unsigned DATA_W = 16
) (
  input wire logic clk_i, srst_i, clock_halving_strap_i, host_bus_clock_i, host_data_lines_oe_o,
  input wire logic upper_byte_strobe_n_i, upper_byte_strobe_n_o, upper_byte_strobe_oe_o, space_select_i,
  input wire logic chip_select_n_i, host_read_i, burst_inhibit_i, bus_tick_o, cycle_sel_o, space_buffer_o,
  input wire logic upper_lane_o, upper_we_o, data_strobe_o,
  input wire logic [3:0] bus_mode_i,
  input wire logic [DATA_W-1:0] host_data_lines_i, host_data_lines_o, core_rdata_i, core_wdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic comp;
  assign comp = (bus_mode_i == 4'h5) || (bus_mode_i == 4'h6);
  property p_rst_float; disable iff (1'b0)
    srst_i |=> !host_data_lines_oe_o && !upper_byte_strobe_oe_o && upper_byte_strobe_n_o; endproperty
  a_rst_float: assert property (p_rst_float) else $error("pins driven during reset");
  property p_refuse; chip_select_n_i && !comp |=> !cycle_sel_o && !host_data_lines_oe_o && !upper_we_o; endproperty
  a_refuse: assert property (p_refuse) else $error("cycle taken without chip select");
  property p_comp_tied; comp |=> cycle_sel_o && space_buffer_o; endproperty
  a_comp_tied: assert property (p_comp_tied) else $error("companion mode select not tied");
  property p_space; !comp |=> space_buffer_o == $past(space_select_i); endproperty
  a_space: assert property (p_space) else $error("space select not followed");
  property p_read; !chip_select_n_i && host_read_i && !comp |=>
    host_data_lines_oe_o && host_data_lines_o == $past(core_rdata_i); endproperty
  a_read: assert property (p_read) else $error("read data not driven");
  property p_swap; comp |=> core_wdata_o == {$past(host_data_lines_i[7:0]), $past(host_data_lines_i[15:8])};
  endproperty
  a_swap: assert property (p_swap) else $error("companion lanes not swapped");
  property p_bi; bus_mode_i == 4'h7 |=> upper_byte_strobe_oe_o && upper_byte_strobe_n_o == !$past(burst_inhibit_i);
  endproperty
  a_bi: assert property (p_bi) else $error("burst inhibit wrong");
  property p_ds; bus_mode_i == 4'h2 && !chip_select_n_i && !upper_byte_strobe_n_i |=> data_strobe_o; endproperty
  a_ds: assert property (p_ds) else $error("data strobe missing");
  property p_tick; !clock_halving_strap_i && !$past(srst_i) && $rose(host_bus_clock_i) |=> bus_tick_o ##1 !bus_tick_o;
  endproperty
  a_tick: assert property (p_tick) else $error("bus tick missing");
  property p_tick_cause; bus_tick_o |-> $past(host_bus_clock_i) && !$past(host_bus_clock_i, 2); endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("bus tick without rise");
endmodule : hbpm_top_chk
bind hbpm_top hbpm_top_chk #(.DATA_W(DATA_W)) u_chk (.clk_i, .srst_i, .clock_halving_strap_i, .host_bus_clock_i,
  .host_data_lines_oe_o, .upper_byte_strobe_n_i, .upper_byte_strobe_n_o, .upper_byte_strobe_oe_o, .space_select_i,
  .chip_select_n_i, .host_read_i, .burst_inhibit_i, .bus_tick_o, .cycle_sel_o, .space_buffer_o, .upper_lane_o,
  .upper_we_o, .data_strobe_o, .bus_mode_i, .host_data_lines_i, .host_data_lines_o, .core_rdata_i, .core_wdata_o);

// >>> verification/tb_host_bus_pin_mapper.sv
// self-checking testbench for the host bus pin mapper
`timescale 1ns/10ps
module tb_host_bus_pin_mapper;
  logic clk_i = 1'b0, srst_i = 1'b1, strap = 1'b0, strb_n = 1'b0, ss = 1'b0, cs_n = 1'b0, rd = 1'b1, bi = 1'b0;
  logic        run = 1'b0, drv = 1'b0;
  logic [3:0]  mode = 4'h7;
  logic [15:0] wdat = 16'h0000, rdat = 16'h0000, pins, dout, wdo;
  logic        doe, sno, soe, tick, sel, spb, lane, we, ds, bclk;
  int          fails = 0, samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  hbpm_host_model host (.clk_i(clk_i), .run_i(run), .drive_i(drv), .wdata_i(wdat), .dev_data_i(dout),
    .dev_oe_i(doe), .bus_clk_o(bclk), .data_o(pins));
  hbpm_top uut (.clk_i(clk_i), .srst_i(srst_i), .bus_mode_i(mode), .clock_halving_strap_i(strap),
    .host_bus_clock_i(bclk), .host_data_lines_i(pins), .host_data_lines_o(dout), .host_data_lines_oe_o(doe),
    .upper_byte_strobe_n_i(strb_n), .upper_byte_strobe_n_o(sno), .upper_byte_strobe_oe_o(soe),
    .space_select_i(ss), .chip_select_n_i(cs_n), .host_read_i(rd), .burst_inhibit_i(bi), .core_rdata_i(rdat),
    .bus_tick_o(tick), .cycle_sel_o(sel), .space_buffer_o(spb), .upper_lane_o(lane), .upper_we_o(we),
    .data_strobe_o(ds), .core_wdata_o(wdo));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // each mode with strobe low, write then read: lane, write enable and single strobe
  task automatic t_strobe;
    logic [2:0] e;
    for (int m = 0; m < 10; m++) begin
      for (int r = 0; r < 2; r++) begin
        @(negedge clk_i);
        mode = m[3:0]; cs_n = 1'b0; strb_n = 1'b0; rd = r[0];
        e = {(m < 9 && m != 7), (m < 9 && m != 7 && (r == 0 || m == 0 || m == 3)), (m == 2)};
        @(negedge clk_i);
        chk({lane, we, ds}, e);
      end
    end
    mode = 4'h1; strb_n = 1'b1; rd = 1'b0;
    @(negedge clk_i); @(negedge clk_i);
    chk({lane, we, ds}, 3'h0);
  endtask : t_strobe
  // back-to-back reads, a refused cycle, then a companion-mode read
  task automatic t_read;
    mode = 4'h0; cs_n = 1'b0; rd = 1'b1; drv = 1'b0; rdat = 16'hA55A;
    @(negedge clk_i); rdat = 16'h1234;
    chk({doe, pins}, {1'b1, 16'hA55A});
    @(negedge clk_i); cs_n = 1'b1;
    chk(dout, 16'h1234);
    @(negedge clk_i); mode = 4'h5;
    chk({sel, doe}, 2'h0);
    @(negedge clk_i);
    chk({sel, doe, dout}, {2'h3, 16'h3412});
  endtask : t_read
  // writes: lane swap in companion mode, straight lanes elsewhere, space select
  task automatic t_write;
    // the device still drives the pins for one more edge after the read; let it let go first
    rd = 1'b0;
    @(negedge clk_i);
    drv = 1'b1; wdat = 16'hBEEF; ss = 1'b0;
    @(negedge clk_i); mode = 4'h0; cs_n = 1'b0;
    chk({spb, wdo}, {1'b1, 16'hEFBE});
    @(negedge clk_i); ss = 1'b1; mode = 4'h7;
    chk({spb, wdo}, {1'b0, 16'hBEEF});
    @(negedge clk_i); bi = 1'b1;
    chk({spb, wdo}, {1'b1, 16'hBEEF});
    @(negedge clk_i); bi = 1'b0;
    chk({soe, sno}, 2'h2);
    @(negedge clk_i); mode = 4'h3;
    chk({soe, sno}, 2'h3);
    @(negedge clk_i); drv = 1'b0;
    chk(soe, 1'b0);
  endtask : t_write
  // reset in mid-run, then count bus ticks over eight bus clock rises
  task automatic t_tick(input logic halve, input int exp);
    int n;
    n = 0;
    srst_i = 1'b1; strap = halve; cs_n = 1'b0; rd = 1'b1; mode = 4'h7;
    @(negedge clk_i); @(negedge clk_i);
    chk({doe, soe, sno}, 3'h1);
    srst_i = 1'b0;
    @(negedge clk_i); run = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (i == 31) run = 1'b0;
      if (tick === 1'b1) n++;
    end
    chk(n[15:0], exp[15:0]);
  endtask : t_tick
  initial begin
    @(negedge clk_i); @(negedge clk_i);
    chk({doe, soe, sno}, 3'h1);
    srst_i = 1'b0;
    @(negedge clk_i);
    t_strobe();
    t_read();
    t_write();
    t_tick(1'b0, 8);
    t_tick(1'b1, 4);
    summarize();
  end
endmodule : tb_host_bus_pin_mapper
